// [shared/fcp_pwm_regs.vh]
`ifndef FCP_PWM_REGS_VH
`define FCP_PWM_REGS_VH

// special register byte addresses
`define FCP_ADDR_WAVEFORM_CONTROL 8'ha1
`define FCP_ADDR_DUTY_CH0         8'ha2
`define FCP_ADDR_DUTY_CH1         8'ha3
`define FCP_ADDR_DUTY_CH2         8'ha4
`define FCP_ADDR_DUTY_CH3         8'ha5
`define FCP_ADDR_CH4_PERIOD       8'haa
`define FCP_ADDR_CH4_PULSE_WIDTH  8'hab
`define FCP_ADDR_DIVIDER0_LOW     8'hb1
`define FCP_ADDR_DIVIDER0_HIGH    8'hb2
`define FCP_ADDR_DIVIDER1_LOW     8'hb3
`define FCP_ADDR_DIVIDER1_HIGH    8'hb4

// waveform_control field positions
`define FCP_BIT_LOW_GROUP_POLARITY 7
`define FCP_BIT_CH4_POLARITY       6
`define FCP_BIT_UNIT_ENABLE        5
`define FCP_BIT_CH4_DRIVE_SELECT   4
`define FCP_LSB_LOW_GROUP_DRIVE    0

// reset values
`define FCP_RESET_BYTE    8'h00
`define FCP_RESET_DIVIDER 16'h0000

// halved system clock: one counting tick every this many cycles
`define FCP_HALF_RATE_CYCLES 2

`endif

// [hdl/fcp_pwm_unit.v]
// Contract
// RULE_01 - shared low-group counter is 8 bits, wraps 255 back to 0.
// RULE_02 - channels 0-3 normal polarity: high while duty exceeds shared counter.
// RULE_03 - channels 0-3 normal polarity: low while duty at or below counter.
// RULE_04 - one polarity bit sets channels 0-3 together; zero is normal sense.
// RULE_05 - duty 00h/ffh constant-level claim conflicts with compare; compare is kept.
// RULE_06 - low group prescaler is 16 bits in two bytes; divides halved clock by n+1.
// RULE_07 - enable bit zero stops the unit, one runs it.
// RULE_08 - drive bits pick open-drain at zero, push-pull at one, per channel.
// RULE_09 - channel 4 has its own polarity bit, independent of channels 0-3.
// RULE_10 - channel 4 prescaler pair divides halved clock by divisor plus one.
// RULE_11 - channel 4 divisor zero clocks its counter at full halved rate.
// RULE_12 - channel 4 free-running 8-bit counter compares pulse width and period.
// RULE_13 - pulse width sits at abh, period at aah.
// RULE_14 - channel 4 goes low once counter reaches pulse width.
// RULE_15 - counter equal to period clears counter and drives output high.
// RULE_16 - enabling loads period and pulse width into working compare registers.
// RULE_17 - rewrites of divisor, width, period take effect at period end only.
// RULE_18 - software keeps period nonzero and above pulse width.
// RULE_19 - polarity one inverts outputs without changing any timing.
// RULE_20 - prescaler pulses once every divisor-plus-one halved-clock ticks, then restarts.
// RULE_21 - disabled: counters and prescalers cleared, outputs at inactive level.
`timescale 1ns/1ps
`include "fcp_pwm_regs.vh"

module fcp_pwm_unit (
  input  wire       clk_sys_in,
  input  wire       nrst_in,
  input  wire       ce_in,
  input  wire [7:0] sfr_addr_in,
  input  wire       sfr_wr_in,
  input  wire [7:0] sfr_wdata_in,
  output reg  [7:0] sfr_rdata_out,
  output reg  [4:0] pwm_level_out,
  output reg  [4:0] pwm_out_out,
  output reg  [4:0] pwm_oe_out
);

  reg  [7:0]  waveform_control_q;
  reg  [7:0]  duty_q [0:3];
  reg  [7:0]  ch4_period_q;
  reg  [7:0]  ch4_pulse_width_q;
  reg  [15:0] divider0_q;
  reg  [15:0] ch4_divider_q;

  reg         half_q;
  reg  [15:0] pre0_cnt_q;
  reg  [7:0]  grp_cnt_q;
  reg  [15:0] pre1_cnt_q;
  reg  [7:0]  ch4_cnt_q;
  reg  [15:0] ch4_div_work_q;
  reg  [7:0]  ch4_per_work_q;
  reg  [7:0]  ch4_pw_work_q;
  reg         ch4_running_q;

  reg  [7:0]  rdata_d;
  reg  [4:0]  level_d;
  reg  [4:0]  drive_d;
  integer     i;

  wire        unit_enable        = waveform_control_q[`FCP_BIT_UNIT_ENABLE];
  wire        low_group_polarity = waveform_control_q[`FCP_BIT_LOW_GROUP_POLARITY];
  wire        ch4_polarity       = waveform_control_q[`FCP_BIT_CH4_POLARITY];
  wire [3:0]  low_group_drive_select = waveform_control_q[`FCP_LSB_LOW_GROUP_DRIVE +: 4];
  wire        ch4_drive_select   = waveform_control_q[`FCP_BIT_CH4_DRIVE_SELECT];

  wire        wr_en   = ce_in & sfr_wr_in;
  // halved system clock tick
  wire        tick    = ce_in & half_q;
  wire        pre0_hit = (pre0_cnt_q == divider0_q);
  wire        adv0    = tick & pre0_hit;
  wire        pre1_hit = (pre1_cnt_q == ch4_div_work_q);
  wire        adv1    = tick & pre1_hit;
  wire        ch4_end = adv1 & (ch4_cnt_q == ch4_per_work_q);

  // pin drive: open drain only pulls low, push-pull drives both levels
  function [1:0] pin_drive;
    input level;
    input push_pull;
    begin
      if (push_pull) begin
        pin_drive = {level, 1'b1};
      end else begin
        pin_drive = {1'b0, ~level};
      end
    end
  endfunction

  // low-group compare: strict greater-than, forced inactive while stopped
  function low_level;
    input [7:0] duty;
    input [7:0] cnt;
    input       run;
    input       invert;
    begin
      low_level = ((duty > cnt) & run) ^ invert;
    end
  endfunction

  // prescaler next count, shared by both dividers
  function [15:0] pre_next;
    input [15:0] cnt;
    input        hit;
    begin
      if (hit) begin
        pre_next = `FCP_RESET_DIVIDER;
      end else begin
        pre_next = cnt + 16'h0001;
      end
    end
  endfunction

  // register writes
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      waveform_control_q <= `FCP_RESET_BYTE;
      duty_q[0]          <= `FCP_RESET_BYTE;
      duty_q[1]          <= `FCP_RESET_BYTE;
      duty_q[2]          <= `FCP_RESET_BYTE;
      duty_q[3]          <= `FCP_RESET_BYTE;
      ch4_period_q       <= `FCP_RESET_BYTE;
      ch4_pulse_width_q  <= `FCP_RESET_BYTE;
    end else if (wr_en) begin
      case (sfr_addr_in)
        `FCP_ADDR_WAVEFORM_CONTROL: begin
          waveform_control_q <= sfr_wdata_in;
        end
        `FCP_ADDR_DUTY_CH0: begin
          duty_q[0] <= sfr_wdata_in;
        end
        `FCP_ADDR_DUTY_CH1: begin
          duty_q[1] <= sfr_wdata_in;
        end
        `FCP_ADDR_DUTY_CH2: begin
          duty_q[2] <= sfr_wdata_in;
        end
        `FCP_ADDR_DUTY_CH3: begin
          duty_q[3] <= sfr_wdata_in;
        end
        // RULE_13 channel 4 addresses
        `FCP_ADDR_CH4_PERIOD: begin
          ch4_period_q <= sfr_wdata_in;
        end
        `FCP_ADDR_CH4_PULSE_WIDTH: begin
          ch4_pulse_width_q <= sfr_wdata_in;
        end
        default: begin
        end
      endcase
    end
  end

  // divisor bytes; each half lands on its own, so a running divider may see a mixed value
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      divider0_q    <= `FCP_RESET_DIVIDER;
      ch4_divider_q <= `FCP_RESET_DIVIDER;
    end else if (wr_en) begin
      case (sfr_addr_in)
        // RULE_06 divisor byte pair
        `FCP_ADDR_DIVIDER0_LOW: begin
          divider0_q[7:0] <= sfr_wdata_in;
        end
        `FCP_ADDR_DIVIDER0_HIGH: begin
          divider0_q[15:8] <= sfr_wdata_in;
        end
        // RULE_10 channel 4 divisor pair
        `FCP_ADDR_DIVIDER1_LOW: begin
          ch4_divider_q[7:0] <= sfr_wdata_in;
        end
        `FCP_ADDR_DIVIDER1_HIGH: begin
          ch4_divider_q[15:8] <= sfr_wdata_in;
        end
        default: begin
        end
      endcase
    end
  end

  // read mux, unmapped addresses read zero
  always @* begin
    case (sfr_addr_in)
      `FCP_ADDR_WAVEFORM_CONTROL: begin
        rdata_d = waveform_control_q;
      end
      `FCP_ADDR_DUTY_CH0: begin
        rdata_d = duty_q[0];
      end
      `FCP_ADDR_DUTY_CH1: begin
        rdata_d = duty_q[1];
      end
      `FCP_ADDR_DUTY_CH2: begin
        rdata_d = duty_q[2];
      end
      `FCP_ADDR_DUTY_CH3: begin
        rdata_d = duty_q[3];
      end
      `FCP_ADDR_CH4_PERIOD: begin
        rdata_d = ch4_period_q;
      end
      `FCP_ADDR_CH4_PULSE_WIDTH: begin
        rdata_d = ch4_pulse_width_q;
      end
      `FCP_ADDR_DIVIDER0_LOW: begin
        rdata_d = divider0_q[7:0];
      end
      `FCP_ADDR_DIVIDER0_HIGH: begin
        rdata_d = divider0_q[15:8];
      end
      `FCP_ADDR_DIVIDER1_LOW: begin
        rdata_d = ch4_divider_q[7:0];
      end
      `FCP_ADDR_DIVIDER1_HIGH: begin
        rdata_d = ch4_divider_q[15:8];
      end
      default: begin
        rdata_d = `FCP_RESET_BYTE;
      end
    endcase
  end

  // shared halved-clock phase; starting from zero puts the first tick two cycles after enable
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      half_q <= 1'b0;
    end else if (ce_in) begin
      if (!unit_enable) begin
        half_q <= 1'b0;
      end else begin
        half_q <= ~half_q;
      end
    end
  end

  // low group: shared prescaler
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pre0_cnt_q <= `FCP_RESET_DIVIDER;
    end else if (ce_in) begin
      // RULE_07 RULE_21 hold cleared while stopped
      if (!unit_enable) begin
        pre0_cnt_q <= `FCP_RESET_DIVIDER;
      end else if (tick) begin
        // RULE_20 restart after each pulse
        pre0_cnt_q <= pre_next(pre0_cnt_q, pre0_hit);
      end
    end
  end

  // low group: shared 8-bit counter
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      grp_cnt_q <= `FCP_RESET_BYTE;
    end else if (ce_in) begin
      if (!unit_enable) begin
        grp_cnt_q <= `FCP_RESET_BYTE;
      end else if (adv0) begin
        // RULE_01 natural 8-bit wrap
        grp_cnt_q <= grp_cnt_q + 8'h01;
      end
    end
  end

  // channel 4: own prescaler, counter and working copies
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pre1_cnt_q     <= `FCP_RESET_DIVIDER;
      ch4_cnt_q      <= `FCP_RESET_BYTE;
      ch4_div_work_q <= `FCP_RESET_DIVIDER;
      ch4_per_work_q <= `FCP_RESET_BYTE;
      ch4_pw_work_q  <= `FCP_RESET_BYTE;
      ch4_running_q  <= 1'b0;
    end else if (ce_in) begin
      if (!unit_enable) begin
        // RULE_21 cleared while stopped
        pre1_cnt_q    <= `FCP_RESET_DIVIDER;
        ch4_cnt_q     <= `FCP_RESET_BYTE;
        ch4_running_q <= 1'b0;
      end else if (!ch4_running_q) begin
        // RULE_16 load working copies on enable
        ch4_div_work_q <= ch4_divider_q;
        ch4_per_work_q <= ch4_period_q;
        ch4_pw_work_q  <= ch4_pulse_width_q;
        ch4_running_q  <= 1'b1;
      end else begin
        if (tick) begin
          // RULE_11 RULE_20 divisor zero hits every tick
          pre1_cnt_q <= pre_next(pre1_cnt_q, pre1_hit);
        end
        if (ch4_end) begin
          // RULE_15 period match clears counter
          ch4_cnt_q <= `FCP_RESET_BYTE;
          // RULE_17 new values only at period end
          ch4_div_work_q <= ch4_divider_q;
          ch4_per_work_q <= ch4_period_q;
          ch4_pw_work_q  <= ch4_pulse_width_q;
        end else if (adv1) begin
          // RULE_12 free-running counter
          ch4_cnt_q <= ch4_cnt_q + 8'h01;
        end
      end
    end
  end

  // compare levels and pin drive
  always @* begin
    level_d = 5'h00;
    drive_d = 5'h00;
    for (i = 0; i < 4; i = i + 1) begin
      // RULE_02 RULE_03 RULE_05 strict compare, 00h stays low
      // RULE_04 RULE_19 shared polarity inversion
      level_d[i] = low_level(duty_q[i], grp_cnt_q, unit_enable, low_group_polarity);
    end
    // RULE_14 RULE_15 high below width, low at or above
    // RULE_09 RULE_19 independent inversion
    level_d[4] = ((ch4_cnt_q < ch4_pw_work_q) & ch4_running_q) ^ ch4_polarity;
    // RULE_08 per-channel drive select
    drive_d = {ch4_drive_select, low_group_drive_select};
  end

  // registered read data, so reads add no path into the pins
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sfr_rdata_out <= `FCP_RESET_BYTE;
    end else if (ce_in) begin
      sfr_rdata_out <= rdata_d;
    end
  end

  // registered logical levels
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pwm_level_out <= 5'h00;
    end else if (ce_in) begin
      pwm_level_out <= level_d;
    end
  end

  // pin value and enable come from one function so they never disagree
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pwm_out_out <= 5'h00;
      pwm_oe_out  <= 5'h00;
    end else if (ce_in) begin
      {pwm_out_out[0], pwm_oe_out[0]} <= pin_drive(level_d[0], drive_d[0]);
      {pwm_out_out[1], pwm_oe_out[1]} <= pin_drive(level_d[1], drive_d[1]);
      {pwm_out_out[2], pwm_oe_out[2]} <= pin_drive(level_d[2], drive_d[2]);
      {pwm_out_out[3], pwm_oe_out[3]} <= pin_drive(level_d[3], drive_d[3]);
      {pwm_out_out[4], pwm_oe_out[4]} <= pin_drive(level_d[4], drive_d[4]);
    end
  end

endmodule

// [bench/fcp_pin_load.sv]
`timescale 1ns/1ps
module fcp_pin_load (
  input  wire logic [4:0] pwm_out_in,
  input  wire logic [4:0] pwm_oe_in,
  output wire logic [4:0] pin_out
);
  // released open drain pins pulled up
  assign pin_out = (pwm_oe_in & pwm_out_in) | ~pwm_oe_in;
endmodule

// [bench/fcp_pwm_sva.sv]
`timescale 1ns/1ps
module fcp_pwm_sva (
  input wire logic       clk_sys_in,
  input wire logic       nrst_in,
  input wire logic       ce_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic       sfr_wr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic [4:0] pwm_level_out,
  input wire logic [4:0] pwm_out_out,
  input wire logic [4:0] pwm_oe_out
);
  logic [7:0] mem_q [256];
  logic [7:0] quiet_q;
  logic [7:0] ctl;
  logic [7:0] rd_exp;
  logic       mapped;
  // unmapped places are never written, so they read back zero
  assign mapped = sfr_addr_in inside {8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'haa, 8'hab,
                                      8'hb1, 8'hb2, 8'hb3, 8'hb4};
  assign ctl = mem_q[8'ha1];
  assign rd_exp = mem_q[sfr_addr_in];
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      quiet_q <= 8'h00;
      for (int i = 0; i < 256; i++) mem_q[i] <= 8'h00;
    end else if (ce_in && sfr_wr_in) begin
      quiet_q <= 8'h00;
      if (mapped) mem_q[sfr_addr_in] <= sfr_wdata_in;
    end else if (quiet_q != 8'hff) begin
      quiet_q <= quiet_q + 8'h01;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  a_read_back: assert property (
    $past(ce_in) && !$past(sfr_wr_in) |-> sfr_rdata_out == $past(rd_exp)) else $error("read data mismatch");
  a_open_drain: assert property (
    quiet_q > 8'h02 |-> ((pwm_out_out | (pwm_oe_out ^ ~pwm_level_out)) & ~ctl[4:0]) == 5'h00)
    else $error("open drain pin wrong");
  a_push_pull: assert property (
    quiet_q > 8'h02 |-> ((~pwm_oe_out | (pwm_out_out ^ pwm_level_out)) & ctl[4:0]) == 5'h00)
    else $error("push pull pin wrong");
  a_disabled_level: assert property (
    quiet_q > 8'h02 && !ctl[5] |-> pwm_level_out == {ctl[6], {4{ctl[7]}}}) else $error("idle level wrong");
  a_duty_zero: assert property (
    quiet_q > 8'h02 && ctl[5] && !ctl[7] && mem_q[8'ha2] == 8'h00 |-> !pwm_level_out[0])
    else $error("zero duty not low");
  a_duty_max: assert property (
    quiet_q > 8'h08 && ctl[5] && !ctl[7] && mem_q[8'hb1] == 8'h00 && mem_q[8'hb2] == 8'h00
    && mem_q[8'ha4] == 8'hff && !pwm_level_out[2] ##1 !pwm_level_out[2] |=> pwm_level_out[2])
    else $error("full duty low too long");
  a_step_gap: assert property (
    quiet_q > 8'h04 && ctl[5] && $changed(pwm_level_out[1]) |=> $stable(pwm_level_out[1]))
    else $error("counter stepped too fast");
  a_ce_freeze: assert property ( // logical levels and read data hold while clock enable is low
    !ce_in |=> $stable(pwm_level_out) && $stable(sfr_rdata_out)) else $error("state moved without enable");
endmodule

bind fcp_pwm_unit fcp_pwm_sva i_sva (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ce_in(ce_in),
  .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
  .pwm_level_out(pwm_level_out), .pwm_out_out(pwm_out_out), .pwm_oe_out(pwm_oe_out));

// [bench/test_fcp_pwm_unit.sv]
`timescale 1ns/1ps
module test_fcp_pwm_unit;
  logic       clk_sys_in = 1'b0;
  logic       nrst_in = 1'b0;
  logic       ce_in = 1'b1;
  logic [7:0] sfr_addr_in = 8'h00;
  logic       sfr_wr_in = 1'b0;
  logic [7:0] sfr_wdata_in = 8'h00;
  wire  [7:0] sfr_rdata_out;
  wire  [4:0] pwm_level_out;
  wire  [4:0] pwm_out_out;
  wire  [4:0] pwm_oe_out;
  wire  [4:0] pin;
  int         n_errors = 0;
  int         num_checks = 0;
  int         hi [5];
  always #5 clk_sys_in = ~clk_sys_in;
  fcp_pwm_unit i_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ce_in(ce_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
    .pwm_level_out(pwm_level_out), .pwm_out_out(pwm_out_out), .pwm_oe_out(pwm_oe_out));
  fcp_pin_load i_load (.pwm_out_in(pwm_out_out), .pwm_oe_in(pwm_oe_out), .pin_out(pin));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    sfr_addr_in <= a;
    sfr_wr_in <= 1'b1;
    sfr_wdata_in <= d;
    @(posedge clk_sys_in);
    sfr_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    sfr_addr_in <= a;
    repeat (2) @(posedge clk_sys_in);
    #1 check({8'h00, sfr_rdata_out}, {8'h00, e});
  endtask
  // counts high pin cycles; a whole number of periods gives a phase-free figure
  task automatic meas(input int n);
    hi = '{default: 0};
    repeat (n) begin
      @(posedge clk_sys_in);
      #1;
      foreach (hi[i]) hi[i] += int'(pin[i]);
    end
  endtask
  task automatic ckall(input int e [5]);
    foreach (e[i]) check(hi[i][15:0], e[i][15:0]);
  endtask
  task automatic t_regs();
    logic [7:0] a [11] = '{8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'haa, 8'hab, 8'hb1, 8'hb2, 8'hb3, 8'hb4};
    foreach (a[i]) rd(a[i], 8'h00); // reset values
    foreach (a[i]) wr(a[i], a[i] & 8'h1f);
    foreach (a[i]) rd(a[i], a[i] & 8'h1f);
    wr(8'ha6, 8'h77);
    rd(8'ha6, 8'h00); // unmapped place
  endtask
  task automatic t_run();
    logic [7:0] a [10] = '{8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'haa, 8'hab};
    logic [7:0] d [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'hff, 8'h01, 8'h09, 8'h03};
    foreach (a[i]) wr(a[i], d[i]);
    wr(8'ha1, 8'h2a);
    repeat (600) @(posedge clk_sys_in);
    meas(2560);
    ckall('{0, 1280, 2550, 10, 768});
    wr(8'ha1, 8'hea);
    repeat (600) @(posedge clk_sys_in);
    meas(2560);
    ckall('{2560, 1280, 10, 2550, 1792});
    wr(8'ha1, 8'h2a);
    wr(8'hb1, 8'h01);
    wr(8'hb3, 8'h01);
    wr(8'hab, 8'h05);
    repeat (1100) @(posedge clk_sys_in);
    meas(5120);
    ckall('{0, 2560, 5100, 20, 2560});
  endtask
  task automatic t_off();
    wr(8'ha1, 8'hc0);
    repeat (4) @(posedge clk_sys_in);
    #1 check({11'h000, pin}, 16'h001f);
    ce_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    ce_in <= 1'b1;
    wr(8'ha1, 8'h00);
    repeat (4) @(posedge clk_sys_in);
    #1 check({11'h000, pin}, 16'h0000);
  endtask
  task automatic conclude();
    $display("checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    t_regs();
    t_run();
    t_off();
    conclude();
  end
endmodule
